// ===== hw/tpc_config_table.sv
// Function
// RL1: update command stores data byte at index in chosen processor's table
// RL2: writing location 1 also rewrites byte 5 of bright object sequencer file
// RL3: locations 2-3 lower and 6-7 upper event amplitude window bounds
// RL4: locations 4-5 hold boundary column X, that column is event type zero
// RL5: location 8 fast, location 9 slow filter wheel step rate
// RL6: locations 12 and 13 hold last diagnostic patch X and Y
// RL7: location 14 bits 0, 2, 3 inhibit offset, adjacent line, bad pixel handling
// RL8: location 14 bit 1 skips anti-coincidence, events become type zero or one
// RL9: location 14 bits 4-7 event class threshold, lower classes pass
// RL10: locations 15-16 carry 10-bit gatti offset, bit 15 inhibits ramping
// RL11: location 17 bits 0-3 mask, a one blocks that channel's input
// RL12: location 17 bit 7 selects fixed memory dump
// RL13: location 18 is pre-processor control, codes 40h stripe, 50h imaging info
// RL14: locations 19-20 channel 1 threshold, bit 12 makes it automatic offset
// RL15: bit 13 enables overflow offset adjust, bit 14 adjusts every overflow
// RL16: bit 15 of each threshold field enables frame discarding after overrun
// RL17: locations 21-26 hold channel 2, 3, 4 thresholds, same layout
// RL18: location 27 bits 0-3 pick end-of-frame interrupt source pre-processor
// RL19: location 28 holds sequencer file number times two
// RL20: location 29 bits 0-3 disable channel pairs and housekeeping interfaces
// RL21: location 29 bit 4 clock A or B, bit 5 main or alternate telescope
// RL22: commander keeps location 29 bits 6-7 at one
// RL23: update with index above 29 is ignored, nothing changes
`timescale 1ns/1ps
`default_nettype none
module tpc_config_table #(
	parameter int NUM_LOC = 30
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic table_update_command,
	input wire logic remote_processor_select,
	input wire logic [4:0] cmd_index,
	input wire logic [7:0] cmd_data,
	output logic cmd_done,
	output logic cmd_ignored,
	output logic bright_seq_write,
	output logic bright_seq_remote,
	output logic [7:0] bright_seq_pos,
	output logic [7:0] bright_seq_data,
	output logic [1:0][7:0] spare_location,
	output logic [1:0][7:0] bright_integration_time,
	output logic [1:0][15:0] amp_window_low,
	output logic [1:0][15:0] boundary_column_x,
	output logic [1:0][15:0] amp_window_high,
	output logic [1:0][7:0] wheel_fast_rate,
	output logic [1:0][7:0] wheel_slow_rate,
	output logic [1:0][15:0] bad_pixel_flags,
	output logic [1:0][7:0] diag_patch_x,
	output logic [1:0][7:0] diag_patch_y,
	output logic [1:0] offset_sub_inhibit,
	output logic [1:0] anticoinc_inhibit,
	output logic [1:0] adj_line_inhibit,
	output logic [1:0] bad_pixel_inhibit,
	output logic [1:0][3:0] event_class_threshold,
	output logic [1:0][9:0] gatti_offset,
	output logic [1:0] gatti_ramp_inhibit,
	output logic [1:0][3:0] dma_channel_block,
	output logic [1:0] fixed_dump_select,
	output logic [1:0][7:0] preproc_control,
	output logic [1:0] diag_stripe_mode,
	output logic [1:0] imaging_diag_info,
	output logic [1:0][3:0][11:0] thr_amplitude,
	output logic [1:0][3:0] thr_auto,
	output logic [1:0][3:0] thr_adjust_enable,
	output logic [1:0][3:0] thr_adjust_every,
	output logic [1:0][3:0] thr_ditch_enable,
	output logic [1:0][3:0] frame_interrupt_source,
	output logic [1:0][2:0] sequencer_file_number,
	output logic [1:0] ch12_disable,
	output logic [1:0] ch34_disable,
	output logic [1:0] hk_normal_disable,
	output logic [1:0] hk_alt_disable,
	output logic [1:0] clock_a_select,
	output logic [1:0] main_telescope_select,
	output logic [1:0][1:0] wheel_mech_control
);
	logic [NUM_LOC-1:0][7:0] tbl [2];
	logic in_range;
	logic done_q;
	logic done_d;
	logic ignored_q;
	logic ignored_d;
	logic seq_wr_q;
	logic seq_wr_d;
	logic seq_remote_q;
	logic seq_remote_d;
	logic [7:0] seq_data_q;
	logic [7:0] seq_data_d;

	if (NUM_LOC != tpc_pkg::TPC_NUM_LOC)
	begin : g_bad_param
		$error("tpc_config_table: table must hold the full location set");
	end

	function automatic logic [15:0] word_at(
		input logic [NUM_LOC-1:0][7:0] t,
		input logic [4:0] idx
	);
		word_at = {t[idx], t[idx + 5'h01]};
	endfunction : word_at

	assign in_range = (cmd_index <= tpc_pkg::TPC_LOC_LAST); // [RL23]

	always_comb
	begin
		done_d = table_update_command && in_range;
		ignored_d = table_update_command && !in_range; // [RL23]
		// the integration time is mirrored into the sequencer file as it is stored
		seq_wr_d = done_d && (cmd_index == tpc_pkg::TPC_LOC_BRIGHT); // [RL2]
		seq_remote_d = seq_wr_d ? remote_processor_select : seq_remote_q;
		seq_data_d = seq_wr_d ? cmd_data : seq_data_q; // [RL2]
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			done_q <= 1'b0;
			ignored_q <= 1'b0;
			seq_wr_q <= 1'b0;
			seq_remote_q <= 1'b0;
			seq_data_q <= 8'h00;
		end
		else
		begin
			done_q <= done_d;
			ignored_q <= ignored_d;
			seq_wr_q <= seq_wr_d;
			seq_remote_q <= seq_remote_d;
			seq_data_q <= seq_data_d;
		end
	end

	assign cmd_done = done_q;
	assign cmd_ignored = ignored_q;
	assign bright_seq_write = seq_wr_q;
	assign bright_seq_remote = seq_remote_q;
	assign bright_seq_pos = tpc_pkg::TPC_BRIGHT_SEQ_POS; // [RL2]
	assign bright_seq_data = seq_data_q;

	for (genvar p = 0; p < tpc_pkg::TPC_NUM_PROC; p++)
	begin : g_proc
		logic wr_en;
		tpc_pkg::tpc_pp_mode_t mode_q;
		tpc_pkg::tpc_pp_mode_t mode_d;
		logic [3:0] every_q;
		logic [3:0] every_d;

		// index 0 is the local processor, 1 the remote one
		assign wr_en = table_update_command && in_range &&
			(remote_processor_select == 1'(p)); // [RL1] [RL23]

		tpc_table_bank #(
			.NUM_LOC(NUM_LOC),
			.WIDTH(tpc_pkg::TPC_BYTE_W)
		) u_bank (
			.clk(clk),
			.rst(rst),
			.wr_en(wr_en),
			.wr_index(cmd_index),
			.wr_data(cmd_data),
			.table_q(tbl[p])
		);

		assign spare_location[p] = tbl[p][tpc_pkg::TPC_LOC_SPARE];
		assign bright_integration_time[p] = tbl[p][tpc_pkg::TPC_LOC_BRIGHT]; // [RL2]
		assign amp_window_low[p] = word_at(tbl[p], tpc_pkg::TPC_LOC_AMP_LOW); // [RL3]
		assign amp_window_high[p] = word_at(tbl[p], tpc_pkg::TPC_LOC_AMP_HIGH); // [RL3]
		assign boundary_column_x[p] = word_at(tbl[p], tpc_pkg::TPC_LOC_BOUNDARY); // [RL4]
		assign wheel_fast_rate[p] = tbl[p][tpc_pkg::TPC_LOC_FAST]; // [RL5]
		assign wheel_slow_rate[p] = tbl[p][tpc_pkg::TPC_LOC_SLOW]; // [RL5]
		assign bad_pixel_flags[p] = word_at(tbl[p], tpc_pkg::TPC_LOC_BADPIX);
		assign diag_patch_x[p] = tbl[p][tpc_pkg::TPC_LOC_PATCH_X]; // [RL6]
		assign diag_patch_y[p] = tbl[p][tpc_pkg::TPC_LOC_PATCH_Y]; // [RL6]

		assign offset_sub_inhibit[p] =
			tbl[p][tpc_pkg::TPC_LOC_EVT_CTRL][tpc_pkg::TPC_EVT_NO_OFFSET]; // [RL7]
		// consumers classify every event as type zero or one while this is set
		assign anticoinc_inhibit[p] =
			tbl[p][tpc_pkg::TPC_LOC_EVT_CTRL][tpc_pkg::TPC_EVT_NO_ANTICOINC]; // [RL8]
		assign adj_line_inhibit[p] =
			tbl[p][tpc_pkg::TPC_LOC_EVT_CTRL][tpc_pkg::TPC_EVT_NO_ADJ_LINE]; // [RL7]
		assign bad_pixel_inhibit[p] =
			tbl[p][tpc_pkg::TPC_LOC_EVT_CTRL][tpc_pkg::TPC_EVT_NO_BADPIX]; // [RL7]
		assign event_class_threshold[p] = tbl[p][tpc_pkg::TPC_LOC_EVT_CTRL]
			[tpc_pkg::TPC_EVT_CLASS_LSB +: tpc_pkg::TPC_EVT_CLASS_W]; // [RL9]

		assign gatti_offset[p] = word_at(tbl[p], tpc_pkg::TPC_LOC_GATTI)
			[tpc_pkg::TPC_GATTI_OFS_W-1:0]; // [RL10]
		assign gatti_ramp_inhibit[p] = word_at(tbl[p], tpc_pkg::TPC_LOC_GATTI)
			[tpc_pkg::TPC_GATTI_RAMP_INH]; // [RL10]

		assign dma_channel_block[p] =
			tbl[p][tpc_pkg::TPC_LOC_DMA][tpc_pkg::TPC_DMA_MASK_W-1:0]; // [RL11]
		assign fixed_dump_select[p] =
			tbl[p][tpc_pkg::TPC_LOC_DMA][tpc_pkg::TPC_DMA_DUMP]; // [RL12]
		assign preproc_control[p] = tbl[p][tpc_pkg::TPC_LOC_PREPROC]; // [RL13]

		assign frame_interrupt_source[p] =
			tbl[p][tpc_pkg::TPC_LOC_FRAME_IRQ][tpc_pkg::TPC_IRQ_SRC_W-1:0]; // [RL18]
		// the stored value is twice the file number, so bit 0 is dropped
		assign sequencer_file_number[p] =
			tbl[p][tpc_pkg::TPC_LOC_SEQ_FILE][tpc_pkg::TPC_SEQ_NUM_W:1]; // [RL19]

		assign ch12_disable[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_CH12_OFF]; // [RL20]
		assign ch34_disable[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_CH34_OFF]; // [RL20]
		assign hk_normal_disable[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_HK_NORM_OFF]; // [RL20]
		assign hk_alt_disable[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_HK_ALT_OFF]; // [RL20]
		assign clock_a_select[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_CLOCK_A]; // [RL21]
		assign main_telescope_select[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_MAIN_TEL]; // [RL21]
		// stored as commanded; reset leaves both bits at one
		assign wheel_mech_control[p] =
			tbl[p][tpc_pkg::TPC_LOC_BUS_CTRL][tpc_pkg::TPC_BUS_WHEEL_LSB +: 2]; // [RL22]

		for (genvar c = 0; c < tpc_pkg::TPC_NUM_CH; c++)
		begin : g_chan
			logic [15:0] thr_word;

			assign thr_word = word_at(tbl[p],
				5'(int'(tpc_pkg::TPC_LOC_CH1_THR) + 2 * c)); // [RL14] [RL17]
			assign thr_amplitude[p][c] = thr_word[tpc_pkg::TPC_THR_AMP_W-1:0]; // [RL14]
			assign thr_auto[p][c] = thr_word[tpc_pkg::TPC_THR_AUTO]; // [RL14]
			assign thr_adjust_enable[p][c] = thr_word[tpc_pkg::TPC_THR_ADJ]; // [RL15]
			assign thr_ditch_enable[p][c] = thr_word[tpc_pkg::TPC_THR_DITCH]; // [RL16]
			// every-overflow only counts when adjustment is enabled at all
			assign every_d[c] = thr_word[tpc_pkg::TPC_THR_EVERY] &&
				thr_word[tpc_pkg::TPC_THR_ADJ]; // [RL15]
		end

		// an unlisted control code, including the garbled patch code, reads as other
		always_comb
		begin
			unique case (tbl[p][tpc_pkg::TPC_LOC_PREPROC])
				tpc_pkg::TPC_PP_STRIPE: mode_d = tpc_pkg::TPC_PPM_STRIPE; // [RL13]
				tpc_pkg::TPC_PP_IMG_INFO: mode_d = tpc_pkg::TPC_PPM_IMG_INFO; // [RL13]
				default: mode_d = tpc_pkg::TPC_PPM_OTHER;
			endcase
		end

		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
			begin
				mode_q <= tpc_pkg::TPC_PPM_OTHER;
				every_q <= 4'h0;
			end
			else
			begin
				mode_q <= mode_d;
				every_q <= every_d;
			end
		end

		assign diag_stripe_mode[p] = (mode_q == tpc_pkg::TPC_PPM_STRIPE);
		assign imaging_diag_info[p] = (mode_q == tpc_pkg::TPC_PPM_IMG_INFO);
		assign thr_adjust_every[p] = every_q;
	end

	a_store_local: assert property ( // [RL1]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && in_range)
		|=> (tbl[0][$past(cmd_index)] == $past(cmd_data)) && cmd_done
	) else $error("local table location not updated by command");

	a_remote_untouched: assert property ( // [RL1]
		@(posedge clk) disable iff (rst)
		(table_update_command && remote_processor_select)
		|=> (tbl[0] == $past(tbl[0]))
	) else $error("remote command changed the local table");

	a_bright_mirror: assert property ( // [RL2]
		@(posedge clk) disable iff (rst)
		(table_update_command && in_range && cmd_index == tpc_pkg::TPC_LOC_BRIGHT)
		|=> bright_seq_write && (bright_seq_data == $past(cmd_data))
			&& (bright_seq_remote == $past(remote_processor_select))
	) else $error("bright integration time not mirrored to sequencer file");

	a_range_ignore: assert property ( // [RL23]
		@(posedge clk) disable iff (rst)
		(table_update_command && cmd_index > tpc_pkg::TPC_LOC_LAST)
		|=> cmd_ignored && !cmd_done && (tbl[0] == $past(tbl[0]))
			&& (tbl[1] == $past(tbl[1]))
	) else $error("out of range update changed the table");

	a_window_low_byte: assert property ( // [RL3]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && cmd_index == 5'h03)
		|=> amp_window_low[0][7:0] == $past(cmd_data)
	) else $error("amplitude window low byte not stored");

	a_boundary_high: assert property ( // [RL4]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && cmd_index == 5'h04)
		|=> boundary_column_x[0][15:8] == $past(cmd_data)
	) else $error("boundary column high byte not stored");

	a_anticoinc_bit: assert property ( // [RL8]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && cmd_index == 5'h0e)
		|=> (anticoinc_inhibit[0] == $past(cmd_data[1]))
			&& (event_class_threshold[0] == $past(cmd_data[7:4]))
	) else $error("event control byte not decoded");

	a_dma_mask: assert property ( // [RL11]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && cmd_index == 5'h11)
		|=> (dma_channel_block[0] == $past(cmd_data[3:0]))
			&& (fixed_dump_select[0] == $past(cmd_data[7]))
	) else $error("dma mask byte not decoded");

	a_stripe_mode: assert property ( // [RL13]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && cmd_index == 5'h12
			&& cmd_data == 8'h40)
		|-> ##2 diag_stripe_mode[0] && !imaging_diag_info[0]
	) else $error("stripe mode code not decoded");

	a_every_needs_adj: assert property ( // [RL15]
		@(posedge clk) disable iff (rst)
		(thr_adjust_every[0] & ~$past(thr_adjust_enable[0])) == 4'h0
			&& (thr_adjust_every[1] & ~$past(thr_adjust_enable[1])) == 4'h0
	) else $error("every-overflow set without adjustment enable");

	a_clock_select: assert property ( // [RL21]
		@(posedge clk) disable iff (rst)
		(table_update_command && !remote_processor_select && cmd_index == 5'h1d)
		|=> (clock_a_select[0] == $past(cmd_data[4]))
			&& (main_telescope_select[0] == $past(cmd_data[5]))
	) else $error("bus control bits not stored");
endmodule : tpc_config_table
`default_nettype wire

// ===== hw/tpc_pkg.sv
package tpc_pkg;
	// table geometry
	localparam int TPC_NUM_LOC = 30;
	localparam int TPC_IDX_W = 5;
	localparam int TPC_BYTE_W = 8;
	localparam int TPC_NUM_PROC = 2;
	localparam int TPC_NUM_CH = 4;
	// location indices; a two-byte field starts at its index, first byte most significant
	localparam logic [4:0] TPC_LOC_SPARE = 5'h00;
	localparam logic [4:0] TPC_LOC_BRIGHT = 5'h01;
	localparam logic [4:0] TPC_LOC_AMP_LOW = 5'h02;
	localparam logic [4:0] TPC_LOC_BOUNDARY = 5'h04;
	localparam logic [4:0] TPC_LOC_AMP_HIGH = 5'h06;
	localparam logic [4:0] TPC_LOC_FAST = 5'h08;
	localparam logic [4:0] TPC_LOC_SLOW = 5'h09;
	localparam logic [4:0] TPC_LOC_BADPIX = 5'h0a;
	localparam logic [4:0] TPC_LOC_PATCH_X = 5'h0c;
	localparam logic [4:0] TPC_LOC_PATCH_Y = 5'h0d;
	localparam logic [4:0] TPC_LOC_EVT_CTRL = 5'h0e;
	localparam logic [4:0] TPC_LOC_GATTI = 5'h0f;
	localparam logic [4:0] TPC_LOC_DMA = 5'h11;
	localparam logic [4:0] TPC_LOC_PREPROC = 5'h12;
	localparam logic [4:0] TPC_LOC_CH1_THR = 5'h13;
	localparam logic [4:0] TPC_LOC_FRAME_IRQ = 5'h1b;
	localparam logic [4:0] TPC_LOC_SEQ_FILE = 5'h1c;
	localparam logic [4:0] TPC_LOC_BUS_CTRL = 5'h1d;
	localparam logic [4:0] TPC_LOC_LAST = 5'h1d;
	// reset values
	localparam logic [7:0] TPC_LOC_RESET = 8'h00;
	localparam logic [7:0] TPC_BUS_CTRL_RESET = 8'hc0;
	// sequencer file byte replaced by the bright object integration time
	localparam logic [7:0] TPC_BRIGHT_SEQ_POS = 8'h05;
	// event processing control bits
	localparam int TPC_EVT_NO_OFFSET = 0;
	localparam int TPC_EVT_NO_ANTICOINC = 1;
	localparam int TPC_EVT_NO_ADJ_LINE = 2;
	localparam int TPC_EVT_NO_BADPIX = 3;
	localparam int TPC_EVT_CLASS_LSB = 4;
	localparam int TPC_EVT_CLASS_W = 4;
	// gatti field
	localparam int TPC_GATTI_OFS_W = 10;
	localparam int TPC_GATTI_RAMP_INH = 15;
	// dma byte
	localparam int TPC_DMA_MASK_W = 4;
	localparam int TPC_DMA_DUMP = 7;
	// pre-processor control codes
	localparam logic [7:0] TPC_PP_STRIPE = 8'h40;
	localparam logic [7:0] TPC_PP_IMG_INFO = 8'h50;
	// channel threshold field
	localparam int TPC_THR_AMP_W = 12;
	localparam int TPC_THR_AUTO = 12;
	localparam int TPC_THR_ADJ = 13;
	localparam int TPC_THR_EVERY = 14;
	localparam int TPC_THR_DITCH = 15;
	// frame interrupt source and sequencer file
	localparam int TPC_IRQ_SRC_W = 4;
	localparam int TPC_SEQ_NUM_W = 3;
	// telescope bus control bits
	localparam int TPC_BUS_CH12_OFF = 0;
	localparam int TPC_BUS_CH34_OFF = 1;
	localparam int TPC_BUS_HK_NORM_OFF = 2;
	localparam int TPC_BUS_HK_ALT_OFF = 3;
	localparam int TPC_BUS_CLOCK_A = 4;
	localparam int TPC_BUS_MAIN_TEL = 5;
	localparam int TPC_BUS_WHEEL_LSB = 6;

	typedef enum logic [1:0] {
		TPC_PPM_OTHER = 2'b00,
		TPC_PPM_STRIPE = 2'b01,
		TPC_PPM_IMG_INFO = 2'b11
	} tpc_pp_mode_t;
endpackage : tpc_pkg

// ===== hw/tpc_table_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_table_bank #(
	parameter int NUM_LOC = 30,
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [4:0] wr_index,
	input wire logic [WIDTH-1:0] wr_data,
	output var logic [NUM_LOC-1:0][WIDTH-1:0] table_q
);
	logic [NUM_LOC-1:0][WIDTH-1:0] table_d;

	if (NUM_LOC > 32 || NUM_LOC < 1 || WIDTH != 8)
	begin : g_bad_param
		$error("tpc_table_bank: unsupported geometry");
	end

	always_comb
	begin
		table_d = table_q;
		// out-of-range indices leave every location untouched
		if (wr_en && (32'(wr_index) < NUM_LOC))
		begin
			table_d[wr_index] = wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NUM_LOC; i++)
			begin
				table_q[i] <= (i == int'(tpc_pkg::TPC_LOC_BUS_CTRL)) ?
					tpc_pkg::TPC_BUS_CTRL_RESET : tpc_pkg::TPC_LOC_RESET;
			end
		end
		else
		begin
			table_q <= table_d;
		end
	end
endmodule : tpc_table_bank
`default_nettype wire

// ===== tb/tpc_cmd_source.sv
`timescale 1ns/1ps
`default_nettype none
module tpc_cmd_source (
	input wire logic clk,
	output logic table_update_command,
	output logic remote_processor_select,
	output logic [4:0] cmd_index,
	output logic [7:0] cmd_data
);
	initial
	begin
		table_update_command = 1'b0;
		remote_processor_select = 1'b0;
		cmd_index = 5'h00;
		cmd_data = 8'h00;
	end

	// holds the command from this edge on; calling again gives back-to-back commands
	task automatic send(input logic remote, input logic [4:0] idx, input logic [7:0] data);
		@(posedge clk);
		table_update_command <= 1'b1;
		remote_processor_select <= remote;
		cmd_index <= idx;
		if (idx == 5'h1d)
			cmd_data <= data | 8'hc0;
		else
			cmd_data <= data;
	endtask : send

	// released index and data lines are inverted so a stale value is never mistaken for a live one
	task automatic idle();
		@(posedge clk);
		table_update_command <= 1'b0;
		cmd_index <= ~cmd_index;
		cmd_data <= ~cmd_data;
	endtask : idle
endmodule : tpc_cmd_source
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst, table_update_command, remote_processor_select;
	logic [4:0] cmd_index;
	logic [7:0] cmd_data, bright_seq_pos, bright_seq_data;
	logic cmd_done, cmd_ignored, bright_seq_write, bright_seq_remote;
	logic [1:0][7:0] spare_location, bright_integration_time, wheel_fast_rate, wheel_slow_rate;
	logic [1:0][7:0] diag_patch_x, diag_patch_y, preproc_control;
	logic [1:0][15:0] amp_window_low, boundary_column_x, amp_window_high, bad_pixel_flags;
	logic [1:0] offset_sub_inhibit, anticoinc_inhibit, adj_line_inhibit, bad_pixel_inhibit;
	logic [1:0] gatti_ramp_inhibit, fixed_dump_select, diag_stripe_mode, imaging_diag_info;
	logic [1:0] ch12_disable, ch34_disable, hk_normal_disable, hk_alt_disable;
	logic [1:0] clock_a_select, main_telescope_select;
	logic [1:0][3:0] event_class_threshold, dma_channel_block, frame_interrupt_source;
	logic [1:0][3:0] thr_auto, thr_adjust_enable, thr_adjust_every, thr_ditch_enable;
	logic [1:0][9:0] gatti_offset;
	logic [1:0][3:0][11:0] thr_amplitude;
	logic [1:0][2:0] sequencer_file_number;
	logic [1:0][1:0] wheel_mech_control;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;

	tpc_config_table #(.NUM_LOC(30)) dut (.clk, .rst, .table_update_command,
		.remote_processor_select, .cmd_index, .cmd_data, .cmd_done, .cmd_ignored,
		.bright_seq_write, .bright_seq_remote, .bright_seq_pos, .bright_seq_data,
		.spare_location, .bright_integration_time, .amp_window_low, .boundary_column_x,
		.amp_window_high, .wheel_fast_rate, .wheel_slow_rate, .bad_pixel_flags, .diag_patch_x,
		.diag_patch_y, .offset_sub_inhibit, .anticoinc_inhibit, .adj_line_inhibit,
		.bad_pixel_inhibit, .event_class_threshold, .gatti_offset, .gatti_ramp_inhibit,
		.dma_channel_block, .fixed_dump_select, .preproc_control, .diag_stripe_mode,
		.imaging_diag_info, .thr_amplitude, .thr_auto, .thr_adjust_enable, .thr_adjust_every,
		.thr_ditch_enable, .frame_interrupt_source, .sequencer_file_number, .ch12_disable,
		.ch34_disable, .hk_normal_disable, .hk_alt_disable, .clock_a_select,
		.main_telescope_select, .wheel_mech_control);

	tpc_cmd_source u_src (.clk, .table_update_command, .remote_processor_select, .cmd_index,
		.cmd_data);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// ceiling is about twenty-five times the expected run
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			summarize();
		end
	end

	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic wr(input logic r, input logic [4:0] i, input logic [7:0] d);
		u_src.send(r, i, d);
		u_src.idle();
		#1;
		chk(cmd_done === (i <= 5'h1d) && cmd_ignored === (i > 5'h1d)
			&& bright_seq_write === (i == 5'h01), "command answer");
	endtask : wr

	// two commands back to back, first location carries the high byte
	task automatic wr2(input logic r, input logic [4:0] i, input logic [15:0] w);
		u_src.send(r, i, w[15:8]);
		u_src.send(r, i + 5'h01, w[7:0]);
		u_src.idle();
		#1;
		chk(cmd_done === 1'b1 && cmd_ignored === 1'b0, "second write answer");
	endtask : wr2

	task automatic t_reset();
		chk(spare_location === '0 && amp_window_high === '0 && preproc_control === '0, "reset");
		chk(wheel_mech_control === 4'hf && ch12_disable === 2'b00 && clock_a_select === 2'b00,
			"reset bus");
	endtask : t_reset

	task automatic t_bright();
		wr(1'b0, 5'h01, 8'h33);
		chk(bright_seq_write === 1'b1 && bright_seq_data === 8'h33 && bright_seq_remote === 1'b0
			&& bright_seq_pos === 8'h05, "bright mirror local");
		wr(1'b1, 5'h01, 8'hc5);
		chk(bright_seq_remote === 1'b1 && bright_seq_data === 8'hc5, "bright mirror remote");
		chk(bright_integration_time === {8'hc5, 8'h33}, "per processor tables");
	endtask : t_bright

	task automatic t_fields();
		wr2(1'b0, 5'h02, 16'h1234);
		wr2(1'b0, 5'h04, 16'h0155);
		wr2(1'b0, 5'h06, 16'hfedc);
		wr(1'b0, 5'h08, 8'h11);
		wr(1'b0, 5'h09, 8'h22);
		wr(1'b0, 5'h0c, 8'h3c);
		wr(1'b0, 5'h0d, 8'h4d);
		wr2(1'b0, 5'h0a, 16'h5aa5);
		chk(bad_pixel_flags === {16'h0000, 16'h5aa5}, "bad pixel flags");
		chk(amp_window_low[0] === 16'h1234 && amp_window_high[0] === 16'hfedc, "window");
		chk(boundary_column_x[0] === 16'h0155, "boundary");
		chk(wheel_fast_rate[0] === 8'h11 && wheel_slow_rate[0] === 8'h22, "rates");
		chk(diag_patch_x[0] === 8'h3c && diag_patch_y[0] === 8'h4d, "patch");
	endtask : t_fields

	task automatic t_evt();
		for (int b = 0; b < 4; b++)
		begin
			wr(1'b0, 5'h0e, 8'h01 << b);
			chk({bad_pixel_inhibit[0], adj_line_inhibit[0], anticoinc_inhibit[0],
				offset_sub_inhibit[0]} === (4'h1 << b), "event inhibit bits");
		end
		wr(1'b0, 5'h0e, 8'ha0);
		chk(event_class_threshold[0] === 4'ha && offset_sub_inhibit[0] === 1'b0, "class");
	endtask : t_evt

	task automatic t_gatti_dma();
		wr2(1'b1, 5'h0f, 16'h83ff);
		chk(gatti_offset[1] === 10'h3ff && gatti_ramp_inhibit[1] === 1'b1, "gatti on");
		wr2(1'b1, 5'h0f, 16'h7c00);
		chk(gatti_offset[1] === 10'h000 && gatti_ramp_inhibit[1] === 1'b0, "gatti off");
		wr(1'b0, 5'h11, 8'h85);
		chk(dma_channel_block[0] === 4'h5 && fixed_dump_select[0] === 1'b1, "dma");
		wr(1'b0, 5'h11, 8'h0a);
		chk(dma_channel_block[0] === 4'ha && fixed_dump_select[0] === 1'b0, "dma");
	endtask : t_gatti_dma

	task automatic t_preproc();
		logic [7:0] codes[4] = '{8'h40, 8'h50, 8'h58, 8'h00};
		foreach (codes[k])
		begin
			wr(1'b0, 5'h12, codes[k]);
			chk(preproc_control[0] === codes[k], "pre-processor byte");
			@(posedge clk);
			#1;
			chk(diag_stripe_mode[0] === (codes[k] == 8'h40)
				&& imaging_diag_info[0] === (codes[k] == 8'h50), "mode decode");
		end
	endtask : t_preproc

	task automatic t_thr();
		logic [15:0] w[4] = '{16'h1abc, 16'h4123, 16'h6fff, 16'h8001};
		for (int c = 0; c < 4; c++)
			wr2(1'b1, 5'h13 + 5'(2 * c), w[c]);
		@(posedge clk);
		#1;
		for (int c = 0; c < 4; c++)
		begin
			chk(thr_amplitude[1][c] === w[c][11:0] && thr_auto[1][c] === w[c][12], "thr");
			chk(thr_adjust_enable[1][c] === w[c][13]
				&& thr_adjust_every[1][c] === (w[c][14] & w[c][13]), "thr adjust");
			chk(thr_ditch_enable[1][c] === w[c][15], "thr ditch");
		end
	endtask : t_thr

	task automatic t_select();
		wr(1'b0, 5'h1b, 8'hf3);
		chk(frame_interrupt_source[0] === 4'h3, "frame source");
		for (int n = 0; n < 8; n++)
		begin
			wr(1'b0, 5'h1c, 8'(2 * n));
			chk(sequencer_file_number[0] === 3'(n), "sequencer file");
		end
		for (int b = 0; b < 6; b++)
		begin
			wr(1'b1, 5'h1d, 8'h01 << b);
			chk({main_telescope_select[1], clock_a_select[1], hk_alt_disable[1],
				hk_normal_disable[1], ch34_disable[1], ch12_disable[1]} === (6'h01 << b)
				&& wheel_mech_control[1] === 2'b11, "bus control");
		end
	endtask : t_select

	task automatic t_bad_index();
		wr(1'b0, 5'h00, 8'h5a);
		wr(1'b0, 5'h1e, 8'hff);
		wr(1'b1, 5'h1f, 8'h00);
		chk(spare_location === {8'h00, 8'h5a} && ch12_disable === 2'b00
			&& bright_integration_time[1] === 8'hc5
			&& sequencer_file_number[0] === 3'h7, "ignored update");
	endtask : t_bad_index

	// reset in mid-run must restore the table, then the first command lands at once
	task automatic t_mid_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset();
		chk(sequencer_file_number === 6'h00 && main_telescope_select === 2'b00
			&& cmd_done === 1'b0 && bright_seq_data === 8'h00, "mid-run reset");
		wr(1'b0, 5'h0d, 8'h77);
		chk(diag_patch_y === {8'h00, 8'h77}, "first write after reset");
	endtask : t_mid_reset

	initial
	begin
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_bright();
		t_fields();
		t_evt();
		t_gatti_dma();
		t_preproc();
		t_thr();
		t_select();
		t_bad_index();
		t_mid_reset();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
